/* rtl/dpwr_defines.vh */
// Constants for the DAC power-on default and two-wire bus gating block.
// Assumes inclusion by bare name from every design file of the block.
`ifndef DPWR_DEFINES_VH
`define DPWR_DEFINES_VH

// Default values loaded while the supply trip is active
`define DPWR_SHIFT_DEFAULT   8'h40
`define DPWR_SETTING_DEFAULT 7'h20
`define DPWR_SETTING_W       7

// Bus slave address of this device; value is arbitrary
`define DPWR_SLAVE_ADDR      7'h2A

// Bits per byte on the bus, and bit counter width
`define DPWR_BYTE_BITS       4'h8
`define DPWR_CNT_W           4
`define DPWR_CNT_ZERO        4'h0
`define DPWR_CNT_ONE         4'h1

// Synchroniser lanes: serial clock, serial data, supply trip
`define DPWR_SYNC_W          3
`define DPWR_SYNC_IDLE       3'h7
`define DPWR_LANE_SCL        0
`define DPWR_LANE_SDA        1
`define DPWR_LANE_TRIP       2

// Command state machine
`define DPWR_ST_W            3
`define DPWR_ST_IDLE         3'h0
`define DPWR_ST_ADDR         3'h1
`define DPWR_ST_ACK_ADDR     3'h2
`define DPWR_ST_WR_DATA      3'h3
`define DPWR_ST_ACK_DATA     3'h4
`define DPWR_ST_RD_DATA      3'h5
`define DPWR_ST_RD_ACK       3'h6
`define DPWR_ST_IGNORE       3'h7

`endif

/* rtl/dpwr_in_sync.v */
// Three-stage input synchroniser with agreement filter, one lane per bit.
// Assumes asynchronous inputs; the filtered output changes only when
// stages two and three agree, so single-sample glitches are dropped.
`timescale 1ns/10ps
`include "dpwr_defines.vh"

module dpwr_in_sync #(
    parameter [`DPWR_SYNC_W-1:0] RESET_VAL = `DPWR_SYNC_IDLE
) (
    // Clock and reset
    input  wire                    clk,
    input  wire                    resetn,
    input  wire                    clkEn,
    // Lanes
    input  wire [`DPWR_SYNC_W-1:0] rawIn,
    output wire [`DPWR_SYNC_W-1:0] cleanOut
);

    genvar lane;
    generate
        for (lane = 0; lane < `DPWR_SYNC_W; lane = lane + 1) begin : gLane
            reg stage1;
            reg stage2;
            reg stage3;
            reg clean;
            always @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    stage1 <= RESET_VAL[lane];
                    stage2 <= RESET_VAL[lane];
                    stage3 <= RESET_VAL[lane];
                    clean  <= RESET_VAL[lane];
                end else if (clkEn) begin
                    stage1 <= rawIn[lane];
                    stage2 <= stage1;
                    stage3 <= stage2;
                    if (stage2 == stage3) begin
                        clean <= stage3;
                    end
                end
            end
            assign cleanOut[lane] = clean;
        end
    endgenerate

endmodule // dpwr_in_sync

/* rtl/dpwr_top.v */
// Power-on / supply-drop default loading and two-wire slave gating for a
// 7-bit voltage-output DAC setting.
// Assumes one system clock; bus pins and the trip level are asynchronous
// and the bus master is far slower than the clock (oversampled).
`timescale 1ns/10ps
`include "dpwr_defines.vh"

module dpwr_top (
    // Clock and reset
    input  wire                        clk,
    input  wire                        resetn,
    input  wire                        clkEn,
    // Supply trip indication, high while supply is below trip point
    input  wire                        supplyDropTrip,
    // Serial clock pin
    input  wire                        sclIn,
    output reg                         sclOut,
    output reg                         sclDriveN,
    // Serial data pin
    input  wire                        sdaIn,
    output reg                         sdaOut,
    output reg                         sdaDriveN,
    // Status and setting
    output reg  [`DPWR_SETTING_W-1:0]  outputSetting,
    output reg  [7:0]                  serialShiftHolding,
    output reg                         digitalReady,
    output reg                         ifaceActive
);

    wire [`DPWR_SYNC_W-1:0] cleanPins;
    wire                    sclNow;
    wire                    sdaNow;
    wire                    tripNow;

    reg                     sclLast;
    reg                     sdaLast;
    reg [`DPWR_ST_W-1:0]    state;
    reg [`DPWR_CNT_W-1:0]   bitCnt;
    reg                     readDir;

    wire                    sclRise;
    wire                    sclFall;
    wire                    startSeen;
    wire                    stopSeen;
    wire                    byteFull;
    wire                    addrMatch;

    dpwr_in_sync #(
        .RESET_VAL (`DPWR_SYNC_IDLE)
    ) uSync (
        .clk      (clk),
        .resetn   (resetn),
        .clkEn    (clkEn),
        .rawIn    ({supplyDropTrip, sdaIn, sclIn}),
        .cleanOut (cleanPins)
    );

    assign sclNow    = cleanPins[`DPWR_LANE_SCL];
    assign sdaNow    = cleanPins[`DPWR_LANE_SDA];
    assign tripNow   = cleanPins[`DPWR_LANE_TRIP];

    assign sclRise   = sclNow & ~sclLast;
    assign sclFall   = ~sclNow & sclLast;
    // Data moving while the clock is high marks a frame boundary
    assign startSeen = sclNow & sclLast & sdaLast & ~sdaNow;
    assign stopSeen  = sclNow & sclLast & ~sdaLast & sdaNow;
    assign byteFull  = (bitCnt == `DPWR_BYTE_BITS);
    assign addrMatch = (serialShiftHolding[7:1] == `DPWR_SLAVE_ADDR);

    // Serial clock is an input only; its driver stays released
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sclOut    <= 1'b0;
            sclDriveN <= 1'b1;
        end else if (clkEn) begin
            sclOut    <= 1'b0;
            sclDriveN <= 1'b1;
        end
    end

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sclLast <= 1'b1;
            sdaLast <= 1'b1;
        end else if (clkEn) begin
            sclLast <= sclNow;
            sdaLast <= sdaNow;
        end
    end

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state              <= `DPWR_ST_IDLE;
            bitCnt             <= `DPWR_CNT_ZERO;
            readDir            <= 1'b0;
            serialShiftHolding <= `DPWR_SHIFT_DEFAULT;
            outputSetting      <= `DPWR_SETTING_DEFAULT;
            digitalReady       <= 1'b0;
            ifaceActive        <= 1'b0;
            sdaOut             <= 1'b0;
            sdaDriveN          <= 1'b1;
        end else if (clkEn) begin
            sdaOut <= 1'b0;
            if (tripNow) begin
                // Defaults are held for the whole trip, so release finds them already loaded
                serialShiftHolding <= `DPWR_SHIFT_DEFAULT;
                outputSetting      <= `DPWR_SETTING_DEFAULT;
                digitalReady       <= 1'b0;
                ifaceActive        <= 1'b0;
                state              <= `DPWR_ST_IDLE;
                bitCnt             <= `DPWR_CNT_ZERO;
                readDir            <= 1'b0;
                sdaDriveN          <= 1'b1;
            end else if (!digitalReady) begin
                // First cycle after release: bus watching resumes next cycle
                digitalReady <= 1'b1;
            end else if (startSeen) begin
                state       <= `DPWR_ST_ADDR;
                bitCnt      <= `DPWR_CNT_ZERO;
                ifaceActive <= 1'b1;
                sdaDriveN   <= 1'b1;
            end else if (stopSeen) begin
                state       <= `DPWR_ST_IDLE;
                bitCnt      <= `DPWR_CNT_ZERO;
                ifaceActive <= 1'b0;
                sdaDriveN   <= 1'b1;
            end else if (sclRise) begin
                case (state)
                    `DPWR_ST_ADDR, `DPWR_ST_WR_DATA: begin
                        serialShiftHolding <= {serialShiftHolding[6:0], sdaNow};
                        bitCnt             <= bitCnt + `DPWR_CNT_ONE;
                    end
                    `DPWR_ST_RD_DATA: begin
                        bitCnt <= bitCnt + `DPWR_CNT_ONE;
                    end
                    `DPWR_ST_RD_ACK: begin
                        // A released acknowledge ends the read
                        if (sdaNow) begin
                            state <= `DPWR_ST_IGNORE;
                        end else begin
                            serialShiftHolding <= {1'b0, outputSetting};
                            bitCnt             <= `DPWR_CNT_ZERO;
                        end
                    end
                    default: begin
                        state <= state;
                    end
                endcase
            end else if (sclFall) begin
                case (state)
                    `DPWR_ST_ADDR: begin
                        if (byteFull) begin
                            if (addrMatch) begin
                                readDir   <= serialShiftHolding[0];
                                state     <= `DPWR_ST_ACK_ADDR;
                                sdaDriveN <= 1'b0;
                            end else begin
                                // Other address or general call: stay passive
                                state <= `DPWR_ST_IGNORE;
                            end
                        end
                    end
                    `DPWR_ST_ACK_ADDR: begin
                        bitCnt <= `DPWR_CNT_ZERO;
                        if (readDir) begin
                            serialShiftHolding <= {1'b0, outputSetting};
                            state              <= `DPWR_ST_RD_DATA;
                            sdaDriveN          <= 1'b0;
                        end else begin
                            state     <= `DPWR_ST_WR_DATA;
                            sdaDriveN <= 1'b1;
                        end
                    end
                    `DPWR_ST_WR_DATA: begin
                        if (byteFull) begin
                            outputSetting <= serialShiftHolding[`DPWR_SETTING_W-1:0];
                            state         <= `DPWR_ST_ACK_DATA;
                            sdaDriveN     <= 1'b0;
                        end
                    end
                    `DPWR_ST_ACK_DATA: begin
                        // Further data bytes overwrite the setting again
                        bitCnt    <= `DPWR_CNT_ZERO;
                        state     <= `DPWR_ST_WR_DATA;
                        sdaDriveN <= 1'b1;
                    end
                    `DPWR_ST_RD_DATA: begin
                        if (byteFull) begin
                            state     <= `DPWR_ST_RD_ACK;
                            sdaDriveN <= 1'b1;
                        end else begin
                            sdaDriveN <= serialShiftHolding[6];
                            serialShiftHolding <= {serialShiftHolding[6:0], 1'b0};
                        end
                    end
                    `DPWR_ST_RD_ACK: begin
                        state     <= `DPWR_ST_RD_DATA;
                        sdaDriveN <= serialShiftHolding[7];
                    end
                    default: begin
                        sdaDriveN <= 1'b1;
                    end
                endcase
            end
        end
    end

endmodule // dpwr_top

/* verif/dpwr_bus_master.sv */
// Behavioural two-wire bus master driving open-drain lines.
// Assumes the bench resolves wire levels; 1 on an output means released.
`timescale 1ns/10ps
module dpwr_bus_master (
    // Clock
    input wire clk,
    // Wire levels
    input wire sdaLine,
    // Master drive
    output reg mScl,
    output reg mSda
);
    initial begin
        mScl = 1'b1;
        mSda = 1'b1;
    end
    // Ten clocks per phase, twice what the slave needs
    task automatic phase();
        repeat (10) @(negedge clk);
    endtask
    task automatic startCond();
        mSda = 1'b1;
        mScl = 1'b1;
        phase();
        mSda = 1'b0;
        phase();
        mScl = 1'b0;
        phase();
    endtask
    task automatic stopCond();
        mSda = 1'b0;
        phase();
        mScl = 1'b1;
        phase();
        mSda = 1'b1;
        phase();
    endtask
    task automatic clockBit(input b, output s);
        mSda = b;
        phase();
        mScl = 1'b1;
        phase();
        s = sdaLine;
        mScl = 1'b0;
        phase();
    endtask
    task automatic byteXfer(input [7:0] tx, input ackIn, output [7:0] rx, output ackOut);
        for (int i = 7; i >= 0; i--) clockBit(tx[i], rx[i]);
        clockBit(ackIn, ackOut);
    endtask
endmodule // dpwr_bus_master

/* verif/dpwr_top_monitor.sv */
// Port-level checks of power-on defaults, trip gating and bus pin use.
// Assumes bus phases well above the synchroniser lag, so state lags pins.
`timescale 1ns/10ps
module dpwr_top_monitor (
    // Clock and reset
    input wire       clk,
    input wire       resetn,
    input wire       clkEn,
    // Trip and pins
    input wire       supplyDropTrip,
    input wire       sclIn,
    input wire       sclOut,
    input wire       sclDriveN,
    input wire       sdaIn,
    input wire       sdaOut,
    input wire       sdaDriveN,
    // Status
    input wire [6:0] outputSetting,
    input wire [7:0] serialShiftHolding,
    input wire       digitalReady,
    input wire       ifaceActive
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    a_scl_never_driven: assert property (sclDriveN && !sclOut)
        else $error("serial clock pin driven");
    a_sda_open_drain: assert property (!sdaOut)
        else $error("data pin driven high");
    a_trip_defaults: assert property (!digitalReady |-> outputSetting == 7'h20 &&
        serialShiftHolding == 8'h40) else $error("defaults missing while not ready");
    a_trip_quiet: assert property (!digitalReady |-> sdaDriveN && !ifaceActive)
        else $error("bus active while not ready");
    a_trip_response: assert property ((supplyDropTrip && clkEn)[*6] |-> !digitalReady)
        else $error("trip not taken");
    a_release_defaults: assert property ($rose(digitalReady) |-> outputSetting == 7'h20)
        else $error("setting not default at release");
    a_setting_at_ack: assert property (digitalReady && $past(digitalReady) &&
        !$stable(outputSetting) |-> $fell(sdaDriveN)) else $error("setting moved off ack");
    a_stop_idle: assert property ($fell(ifaceActive) && digitalReady |-> sdaIn && sclIn)
        else $error("static state without stop");
    a_start_active: assert property ($rose(ifaceActive) |-> !sdaIn && sclIn)
        else $error("active state without start");
    a_sda_on_low: assert property (digitalReady && $past(digitalReady) &&
        !$stable(sdaDriveN) |-> !sclIn) else $error("data pin moved while clock high");
endmodule // dpwr_top_monitor

/* verif/dpwr_top_test.sv */
// Self-checking bench: reset, trip and bus traffic through a master model.
// Assumes the design header is on the include path.
`timescale 1ns/10ps
`include "dpwr_defines.vh"
`define CHECK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin n_errors++; \
    $display("BAD %s exp %h got %h", nm, exp, got); end end
module dpwr_top_test;
    reg        clk, resetn, trip, ack, clkEn;
    reg  [7:0] rx;
    wire       sclLine, sdaLine, mScl, mSda, sclOut, sclDriveN, sdaOut, sdaDriveN;
    wire       digitalReady, ifaceActive;
    wire [6:0] outputSetting;
    wire [7:0] serialShiftHolding;
    int        n_errors = 0;
    int        num_checks = 0;
    assign sclLine = mScl & (sclDriveN | sclOut);
    assign sdaLine = mSda & (sdaDriveN | sdaOut);
    dpwr_top u_dut (.clk(clk), .resetn(resetn), .clkEn(clkEn), .supplyDropTrip(trip),
        .sclIn(sclLine), .sclOut(sclOut), .sclDriveN(sclDriveN), .sdaIn(sdaLine),
        .sdaOut(sdaOut), .sdaDriveN(sdaDriveN), .outputSetting(outputSetting),
        .serialShiftHolding(serialShiftHolding), .digitalReady(digitalReady),
        .ifaceActive(ifaceActive));
    dpwr_bus_master u_master (.clk(clk), .sdaLine(sdaLine), .mScl(mScl), .mSda(mSda));
    task automatic print_verdict();
        if (n_errors == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic waitReady();
        for (int i = 0; i < 50 && digitalReady !== 1'b1; i++) @(negedge clk);
        `CHECK("ready", 1'b1, digitalReady)
        // A device that never leaves the trip ends the run here
        if (digitalReady !== 1'b1) print_verdict();
    endtask
    task automatic xfer(input [7:0] tx, input ackIn, input expAck, input string nm);
        u_master.byteXfer(tx, ackIn, rx, ack);
        `CHECK(nm, expAck, ack)
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        repeat (100000) @(posedge clk);
        n_errors++;
        print_verdict();
    end
    initial begin
        resetn = 1'b0;
        trip = 1'b0;
        clkEn = 1'b1;
        repeat (8) @(negedge clk);
        `CHECK("setting", 7'h20, outputSetting)
        `CHECK("shift", 8'h40, serialShiftHolding)
        resetn = 1'b1;
        waitReady();
        u_master.startCond();
        `CHECK("active", 1'b1, ifaceActive)
        xfer({`DPWR_SLAVE_ADDR, 1'b0}, 1'b1, 1'b0, "wrAddrAck");
        xfer(8'hD5, 1'b1, 1'b0, "wrDataAck");
        `CHECK("setting", 7'h55, outputSetting)
        u_master.stopCond();
        `CHECK("active", 1'b0, ifaceActive)
        u_master.startCond();
        xfer({`DPWR_SLAVE_ADDR, 1'b1}, 1'b1, 1'b0, "rdAddrAck");
        // Master acknowledge makes the slave send the setting once more
        xfer(8'hFF, 1'b0, 1'b0, "rdAck");
        `CHECK("readData", 8'h55, rx)
        xfer(8'hFF, 1'b1, 1'b1, "rdNack");
        `CHECK("readAgain", 8'h55, rx)
        u_master.startCond();
        xfer({~`DPWR_SLAVE_ADDR, 1'b0}, 1'b1, 1'b1, "badAddr");
        u_master.startCond();
        xfer({`DPWR_SLAVE_ADDR, 1'b0}, 1'b1, 1'b0, "againAck");
        xfer(8'h0A, 1'b1, 1'b0, "againData");
        `CHECK("setting", 7'h0A, outputSetting)
        u_master.startCond();
        xfer({`DPWR_SLAVE_ADDR, 1'b0}, 1'b1, 1'b0, "preTrip");
        trip = 1'b1;
        repeat (10) @(negedge clk);
        `CHECK("setting", 7'h20, outputSetting)
        `CHECK("shift", 8'h40, serialShiftHolding)
        `CHECK("ready", 1'b0, digitalReady)
        `CHECK("active", 1'b0, ifaceActive)
        u_master.startCond();
        xfer({`DPWR_SLAVE_ADDR, 1'b0}, 1'b1, 1'b1, "tripAddr");
        `CHECK("active", 1'b0, ifaceActive)
        trip = 1'b0;
        waitReady();
        `CHECK("setting", 7'h20, outputSetting)
        u_master.startCond();
        xfer({`DPWR_SLAVE_ADDR, 1'b0}, 1'b1, 1'b0, "postAddr");
        xfer(8'h33, 1'b1, 1'b0, "postData");
        `CHECK("setting", 7'h33, outputSetting)
        u_master.stopCond();
        // Frozen clock: the trip must wait until the clock runs again
        clkEn = 1'b0;
        trip = 1'b1;
        repeat (10) @(negedge clk);
        `CHECK("frozenSetting", 7'h33, outputSetting)
        `CHECK("frozenReady", 1'b1, digitalReady)
        clkEn = 1'b1;
        repeat (10) @(negedge clk);
        `CHECK("thawSetting", 7'h20, outputSetting)
        `CHECK("thawReady", 1'b0, digitalReady)
        trip = 1'b0;
        waitReady();
        `CHECK("released", 7'h20, outputSetting)
        print_verdict();
    end
endmodule // dpwr_top_test
bind dpwr_top dpwr_top_monitor u_mon (.clk(clk), .resetn(resetn), .clkEn(clkEn),
    .supplyDropTrip(supplyDropTrip), .sclIn(sclIn), .sclOut(sclOut),
    .sclDriveN(sclDriveN), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaDriveN(sdaDriveN),
    .outputSetting(outputSetting), .serialShiftHolding(serialShiftHolding),
    .digitalReady(digitalReady), .ifaceActive(ifaceActive));
